// file: design/nvc_defs.svh
// Constants of the configuration-memory host: register map, device
// register indices, command bytes and bit timing.
// Assumes a 10 MHz system clock and a 100 kHz serial link.
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH

// =====================================================================
// Own register map (byte addresses on the APB)
`define NVC_A_CTRL 8'h00
`define NVC_A_PTR 8'h04
`define NVC_A_STAT 8'h08
`define NVC_A_DAT0 8'h0c
`define NVC_A_DAT1 8'h10
`define NVC_GO_BIT 3
`define NVC_OP_MAX 3'h5

// =====================================================================
// Device side: target address, register indices, command values
`define NVC_TADDR_HI 5'h16
`define NVC_REG_CNT 8'h30
`define NVC_REG_CTL 8'h31
`define NVC_REG_MADR 8'h33
`define NVC_REG_EDAT 8'h34
`define NVC_REG_SDAT 8'h35
`define NVC_REG_UNLK 8'h38
`define NVC_UNLK_KEY 8'hbe
`define NVC_LOCK_VAL 8'h00
`define NVC_COPY_CMD 8'h40
`define NVC_PROG_CMD 8'h01
`define NVC_BUSY_BIT 2

// =====================================================================
// Timing: quarter of a 10 us bit period, in 100 ns cycles
`define NVC_CLK_NS 100
`define NVC_QTR_NS 2500
`define NVC_QTR_CYC ((`NVC_QTR_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)

`endif

// file: design/nvc_pkg.sv
// Types of the configuration-memory host: states, tokens, bus carriers
// and the whole register state of the controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package nvc_pkg;
  typedef enum logic [4:0] {
    NVC_IDLE = 5'h01, NVC_START = 5'h02, NVC_BIT = 5'h04,
    NVC_STOP = 5'h08, NVC_NEXT = 5'h10
  } nvc_state_t;

  typedef enum logic [1:0] {
    NVC_TK_S = 2'h0, NVC_TK_TX = 2'h1, NVC_TK_RX = 2'h2, NVC_TK_P = 2'h3
  } nvc_tok_t;

  typedef enum logic [2:0] {
    NVC_OP_WR = 3'h0, NVC_OP_RD = 3'h1, NVC_OP_WWR = 3'h2,
    NVC_OP_WRD = 3'h3, NVC_OP_COPY = 3'h4, NVC_OP_PROG = 3'h5
  } nvc_op_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } nvc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } nvc_apb_rsp_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } nvc_pins_t;

  typedef struct packed {
    nvc_state_t st;
    logic [1:0] ph;
    logic [4:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rx;
    logic last;
    logic abort;
    logic [4:0] step;
    logic pre;
    logic [1:0] pstep;
    logic unlk;
    nvc_op_t op;
    logic [1:0] strap;
    logic [7:0] ptr;
    logic [6:0] madr;
    logic [2:0] len;
    logic [7:0][7:0] dbuf;
    logic busy;
    logic nack;
    logic done;
    logic scl_q;
    logic sda_q;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [31:0] prdata;
    logic ack;
    logic slverr;
  } nvc_regs_t;
endpackage : nvc_pkg

`default_nettype wire

// file: design/nvc_host.sv
// Serial-bus host that drives a programmable clock device: block
// register access, memory window access and the EEPROM commit flow.
// Assumes APB software access and open-drain SCL/SDA resolved outside.
//
// Function
// - Block write: start, address plus write, pointer byte, data, stop.
// - Block read: address write, pointer, repeated start, address read.
// - Software writes whole base array plus one page into SRAM.
// - SRAM write: load 51, then write 53 in one transaction.
// - Never access register 51 twice in succession.
// - SRAM read: load 51, then read 53 in one transaction.
// - EEPROM read: load 51, then read 52 in one transaction.
// - No repeated register 51 access while reading EEPROM.
// - EEPROM is programmed only from SRAM, filled beforehand.
// - Poll bit 2 of register 49 until programming finishes.
// - Write key 0xbe to register 56 before programming.
// - Write 0x00 to register 56 afterwards to relock.
// - Reserved bits are always written as zero.
//
// Our own choices: the placing of the registers and register access over APB.
`include "nvc_defs.svh"
`default_nettype none

module nvc_host (
  input wire logic mclk_i,                     // 10 MHz clock
  input wire logic nrst_i,                     // Async reset, low
  input wire nvc_pkg::nvc_apb_req_t apb_req_i, // APB request
  output nvc_pkg::nvc_apb_rsp_t apb_rsp_o,     // APB answer
  input wire logic scl_i,                      // SCL line level
  input wire logic sda_i,                      // SDA line level
  output nvc_pkg::nvc_pins_t pins_o            // Open-drain drives
);
  import nvc_pkg::*;

  nvc_regs_t r_reg;
  nvc_regs_t r_next;
  logic tick;
  logic adv;

  // ===================================================================
  // Quarter-bit divider and stretch-aware phase advance
  assign tick = (r_reg.div == 5'(`NVC_QTR_CYC - 1));
  assign adv = tick && (!r_reg.scl_q || r_reg.scl_sy[1]);

  // ===================================================================
  // Next-state logic
  always_comb begin
    nvc_tok_t tk;
    logic [7:0] tb;
    logic tl;
    logic rd_e;
    logic win_e;
    logic fix_e;
    logic [7:0] ptr_e;
    logic [7:0] d0_e;
    logic [3:0] cnt;
    logic [4:0] idx;
    logic [7:0] aw;
    logic wr;
    tk = NVC_TK_P;
    tb = 8'h00;
    tl = 1'b0;
    r_next = r_reg;
    r_next.scl_sy = {r_reg.scl_sy[0], scl_i};
    r_next.sda_sy = {r_reg.sda_sy[0], sda_i};
    r_next.div = tick ? 5'h00 : r_reg.div + 5'h01;

    // Operation decode; fixed commands keep reserved bits zero
    ptr_e = r_reg.ptr;
    d0_e = r_reg.dbuf[0];
    fix_e = (r_reg.op == NVC_OP_COPY) || (r_reg.op == NVC_OP_PROG);
    if (r_reg.op == NVC_OP_COPY) begin
      ptr_e = `NVC_REG_CTL;
      d0_e = `NVC_COPY_CMD;
    end else if (r_reg.op == NVC_OP_PROG) begin
      case (r_reg.pstep)
        2'h0: begin
          ptr_e = `NVC_REG_UNLK;
          d0_e = `NVC_UNLK_KEY;
        end
        2'h1: begin
          ptr_e = `NVC_REG_CTL;
          d0_e = `NVC_PROG_CMD;
        end
        2'h2: ptr_e = `NVC_REG_CTL;
        default: begin
          ptr_e = `NVC_REG_UNLK;
          d0_e = `NVC_LOCK_VAL;
        end
      endcase
    end
    // Status poll is a one-byte read
    rd_e = (r_reg.op == NVC_OP_RD) || (r_reg.op == NVC_OP_WRD) ||
           ((r_reg.op == NVC_OP_PROG) && (r_reg.pstep == 2'h2));
    win_e = (r_reg.op == NVC_OP_WWR) || (r_reg.op == NVC_OP_WRD);
    cnt = fix_e ? 4'h1 : {1'b0, r_reg.len} + 4'h1;
    aw = {`NVC_TADDR_HI, r_reg.strap, 1'b0};
    idx = rd_e ? r_reg.step - 5'h05 : r_reg.step - 5'h03;

    // Token for the current step
    if (win_e && !r_reg.pre) begin
      case (r_reg.step)
        5'h00: tk = NVC_TK_S;
        5'h01: begin
          tk = NVC_TK_TX;
          tb = aw;
        end
        5'h02: begin
          tk = NVC_TK_TX;
          tb = `NVC_REG_MADR;
        end
        default: begin
          tk = NVC_TK_TX;
          tb = {1'b0, r_reg.madr};
        end
      endcase
    end else if (r_reg.step == 5'h00) begin
      tk = NVC_TK_S;
    end else if (r_reg.step == 5'h01) begin
      tk = NVC_TK_TX;
      tb = aw;
    end else if (r_reg.step == 5'h02) begin
      tk = NVC_TK_TX;
      tb = ptr_e;
    end else if (!rd_e) begin
      tk = (idx < {1'b0, cnt}) ? NVC_TK_TX : NVC_TK_P;
      tb = fix_e ? d0_e : r_reg.dbuf[idx[2:0]];
    end else if (r_reg.step == 5'h03) begin
      tk = NVC_TK_S;
    end else if (r_reg.step == 5'h04) begin
      tk = NVC_TK_TX;
      tb = aw | 8'h01;
    end else begin
      tk = (idx < {1'b0, cnt}) ? NVC_TK_RX : NVC_TK_P;
      tl = (idx == {1'b0, cnt} - 5'h01);
    end

    // APB slave: setup captures data, access completes with no wait
    wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite &&
         r_reg.ack;
    r_next.ack = apb_req_i.psel && !apb_req_i.penable;
    if (apb_req_i.psel && !apb_req_i.penable) begin
      r_next.slverr = 1'b0;
      case (apb_req_i.paddr)
        `NVC_A_CTRL: r_next.prdata = {26'h0, r_reg.strap, 1'b0, r_reg.op};
        `NVC_A_PTR: r_next.prdata = {13'h0, r_reg.len, 1'b0, r_reg.madr,
                                     r_reg.ptr};
        `NVC_A_STAT: r_next.prdata = {21'h0, r_reg.st, r_reg.pstep,
                                      r_reg.unlk, r_reg.busy, r_reg.nack,
                                      r_reg.done};
        `NVC_A_DAT0: r_next.prdata = r_reg.dbuf[3:0];
        `NVC_A_DAT1: r_next.prdata = r_reg.dbuf[7:4];
        default: begin
          r_next.prdata = 32'h0;
          r_next.slverr = 1'b1;
        end
      endcase
    end
    if (wr && !r_reg.busy) begin
      case (apb_req_i.paddr)
        `NVC_A_CTRL: begin
          r_next.strap = apb_req_i.pwdata[5:4];
          if (apb_req_i.pwdata[2:0] <= `NVC_OP_MAX) begin
            r_next.op = nvc_op_t'(apb_req_i.pwdata[2:0]);
            if (apb_req_i.pwdata[`NVC_GO_BIT]) begin
              r_next.busy = 1'b1;
              r_next.nack = 1'b0;
              r_next.done = 1'b0;
              r_next.abort = 1'b0;
              r_next.st = NVC_NEXT;
              r_next.step = 5'h00;
              r_next.pre = 1'b0;
              r_next.pstep = 2'h0;
              r_next.unlk = 1'b0;
            end
          end
        end
        `NVC_A_PTR: begin
          r_next.ptr = apb_req_i.pwdata[7:0];
          r_next.madr = apb_req_i.pwdata[14:8];
          r_next.len = apb_req_i.pwdata[18:16];
        end
        `NVC_A_DAT0: r_next.dbuf[3:0] = apb_req_i.pwdata;
        `NVC_A_DAT1: r_next.dbuf[7:4] = apb_req_i.pwdata;
        default: ;
      endcase
    end

    // Line engine
    case (r_reg.st)
      NVC_IDLE: begin
        r_next.scl_q = 1'b1;
        r_next.sda_q = 1'b1;
      end
      NVC_NEXT: begin
        r_next.ph = 2'h0;
        r_next.bitn = 4'h8;
        r_next.sh = tb;
        r_next.rx = (tk == NVC_TK_RX);
        r_next.last = tl;
        case (tk)
          NVC_TK_S: r_next.st = NVC_START;
          NVC_TK_P: r_next.st = NVC_STOP;
          default: r_next.st = NVC_BIT;
        endcase
      end
      NVC_START: if (adv) begin
        r_next.ph = r_reg.ph + 2'h1;
        case (r_reg.ph)
          2'h0: begin
            r_next.sda_q = 1'b1;
            r_next.scl_q = 1'b0;
          end
          2'h1: r_next.scl_q = 1'b1;
          2'h2: r_next.sda_q = 1'b0;
          default: begin
            r_next.scl_q = 1'b0;
            r_next.step = r_reg.step + 5'h01;
            r_next.st = NVC_NEXT;
          end
        endcase
      end
      NVC_BIT: if (adv) begin
        r_next.ph = r_reg.ph + 2'h1;
        case (r_reg.ph)
          2'h0: begin
            r_next.scl_q = 1'b0;
            if (r_reg.rx) begin
              r_next.sda_q = (r_reg.bitn == 4'h0) ? r_reg.last : 1'b1;
            end else begin
              r_next.sda_q = (r_reg.bitn == 4'h0) ? 1'b1 : r_reg.sh[7];
            end
          end
          2'h1: r_next.scl_q = 1'b1;
          2'h2: begin
            if (r_reg.bitn != 4'h0) begin
              r_next.sh = {r_reg.sh[6:0], r_reg.sda_sy[1]};
            end else if (!r_reg.rx && r_reg.sda_sy[1]) begin
              r_next.nack = 1'b1;
              r_next.abort = 1'b1;
            end
          end
          default: begin
            r_next.scl_q = 1'b0;
            r_next.bitn = r_reg.bitn - 4'h1;
            if (r_reg.bitn == 4'h0) begin
              if (r_reg.rx) begin
                r_next.dbuf[idx[2:0]] = r_reg.sh;
              end
              if (win_e && !r_reg.pre && (r_reg.step == 5'h03)) begin
                r_next.pre = 1'b1;
                r_next.step = 5'h00;
              end else begin
                r_next.step = r_reg.step + 5'h01;
              end
              r_next.st = r_reg.abort ? NVC_STOP : NVC_NEXT;
            end
          end
        endcase
      end
      NVC_STOP: if (adv) begin
        r_next.ph = r_reg.ph + 2'h1;
        case (r_reg.ph)
          2'h0: begin
            r_next.scl_q = 1'b0;
            r_next.sda_q = 1'b0;
          end
          2'h1: r_next.scl_q = 1'b1;
          2'h2: r_next.sda_q = 1'b1;
          default: begin
            // Window address restarts with every transaction
            r_next.step = 5'h00;
            r_next.pre = 1'b0;
            if (!r_reg.abort && (r_reg.op == NVC_OP_PROG) &&
                (r_reg.pstep != 2'h3)) begin
              // Hold at poll while busy bit reads one
              if (r_reg.pstep == 2'h0) begin
                r_next.unlk = 1'b1;
              end
              if (!((r_reg.pstep == 2'h2) &&
                    r_reg.dbuf[0][`NVC_BUSY_BIT])) begin
                r_next.pstep = r_reg.pstep + 2'h1;
              end
              r_next.st = NVC_NEXT;
            end else begin
              r_next.busy = 1'b0;
              r_next.done = 1'b1;
              r_next.st = NVC_IDLE;
            end
          end
        endcase
      end
      default: r_next.st = NVC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
      r_reg.st <= NVC_IDLE;
      r_reg.op <= NVC_OP_WR;
      r_reg.scl_q <= 1'b1;
      r_reg.sda_q <= 1'b1;
      r_reg.scl_sy <= 2'h3;
      r_reg.sda_sy <= 2'h3;
    end else begin
      r_reg <= r_next;
    end
  end

  assign apb_rsp_o = '{prdata: r_reg.prdata, pready: r_reg.ack,
                       pslverr: r_reg.slverr};
  assign pins_o = '{scl_o: 1'b0, scl_oe_n: r_reg.scl_q,
                    sda_o: 1'b0, sda_oe_n: r_reg.sda_q};

  // ===================================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_sda_fall_hi;
    $fell(r_reg.sda_q) && r_reg.scl_q;
  endsequence
  sequence s_sda_rise_hi;
    $rose(r_reg.sda_q) && r_reg.scl_q;
  endsequence

  property p_start_cond;
    s_sda_fall_hi |-> r_reg.st == NVC_START;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("SDA fell with SCL high outside a start");

  property p_stop_cond;
    s_sda_rise_hi |-> r_reg.st == NVC_STOP || r_reg.st == NVC_IDLE;
  endproperty
  a_stop_cond: assert property (p_stop_cond)
    else $error("SDA rose with SCL high outside a stop");

  property p_data_stable;
    (r_reg.st == NVC_BIT) && $changed(r_reg.sda_q) |-> !r_reg.scl_q;
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("SDA changed while SCL high during a byte");

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Quarter-bit ticks too close");

  property p_one_madr;
    r_reg.pre && (r_reg.st != NVC_STOP) |=> r_reg.pre;
  endproperty
  a_one_madr: assert property (p_one_madr)
    else $error("Address prefix repeated in one transaction");

  property p_key_first;
    (r_reg.op == NVC_OP_PROG) && (r_reg.pstep == 2'h1) |-> r_reg.unlk;
  endproperty
  a_key_first: assert property (p_key_first)
    else $error("Commit issued before unlock key");

  property p_poll_clear;
    ($past(r_reg.pstep) == 2'h2) && (r_reg.pstep == 2'h3) |->
      !r_reg.dbuf[0][`NVC_BUSY_BIT];
  endproperty
  a_poll_clear: assert property (p_poll_clear)
    else $error("Left poll while busy bit set");

  property p_relock;
    $fell(r_reg.busy) && (r_reg.op == NVC_OP_PROG) && !r_reg.nack |->
      (r_reg.pstep == 2'h3) && r_reg.unlk;
  endproperty
  a_relock: assert property (p_relock)
    else $error("Commit finished without relock");

  property p_idle_free;
    (r_reg.st == NVC_IDLE) |-> r_reg.scl_q && r_reg.sda_q && !r_reg.busy;
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("Lines held while idle");
endmodule : nvc_host

`default_nettype wire

// file: tb/nvc_dev_model.sv
// Behavioural model of the clock device's serial target port, with its
// registers, shadow SRAM and EEPROM, all three in one byte layout.
// Assumes the bench resolves open-drain SCL and SDA with pull-ups.
`default_nettype none

module nvc_dev_model #(
  parameter logic [1:0] STRAP = 2'h1,
  parameter int PROG_NS = 5000
) (
  input wire logic rst_n_i,  // Power-on reset, low
  input wire logic slow_i,   // Stretch SCL after each ack
  input wire logic scl_i,    // Resolved SCL
  input wire logic sda_i,    // Resolved SDA
  output logic scl_low_o,    // Pull SCL low
  output logic sda_low_o     // Pull SDA low
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] regs [128];
  logic [7:0] sram [128];
  logic [7:0] eep [128];
  logic [7:0] sh, ob, ptr;
  logic [6:0] madr;
  logic [3:0] bitc;
  logic [1:0] nb;
  logic act, fresh, rd, rdp, hack, win, busy;

  // ==================================================================
  // Power-up
  initial begin
    for (int i = 0; i < 128; i++) eep[i] = 8'(i * 7 + 3);
    {act, busy, win, rd, rdp, scl_low_o, sda_low_o} = '0;
  end
  always @(posedge rst_n_i) for (int i = 0; i < 128; i++) regs[i] = eep[i];

  // ==================================================================
  // Register side
  function automatic void put(input logic [7:0] d);
    case (ptr)
      8'h33: begin
        madr = d[6:0];
        win = 1'b1;
      end
      8'h35: if (win) begin
        sram[madr] = d;
        madr++;
      end
      8'h31: begin
        regs[49] = d;
        if (d[6]) for (int i = 0; i < 128; i++) sram[i] = regs[i];
        if (d[0] && regs[56] == 8'hbe && !busy) busy = 1'b1;
      end
      default: regs[ptr[6:0]] = d;
    endcase
    if (ptr[7:1] != 7'h1a) ptr++;
  endfunction : put

  function automatic logic [7:0] fetch();
    logic [7:0] v;
    case (ptr)
      8'h35: v = win ? sram[madr] : 8'hff;
      8'h34: v = (win && !busy) ? eep[madr] : 8'hff;
      8'h31: v = {5'h02, busy, 2'h0};
      default: v = regs[ptr[6:0]];
    endcase
    if (ptr[7:1] == 7'h1a) madr = madr + 7'(win);
    if (ptr[7:1] != 7'h1a) ptr++;
    return v;
  endfunction : fetch

  function automatic logic take();
    if (nb == 2'h0) begin
      if (sh[7:1] != {5'h16, STRAP}) begin
        act = 1'b0;
        return 1'b0;
      end
      rdp = sh[0];
    end else if (nb == 2'h1) begin
      ptr = sh;
    end else begin
      put(sh);
    end
    if (nb != 2'h2) nb++;
    return 1'b1;
  endfunction : take

  always @(posedge busy) begin
    #PROG_NS;
    for (int i = 0; i < 128; i++) eep[i] = sram[i];
    regs[48] = regs[48] + 8'h1;
    busy = 1'b0;
  end

  // ==================================================================
  // Line side
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    {act, fresh, rd, rdp} = 4'b1100;
    nb = 2'h0;
    bitc = 4'h0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    {act, rd, win} = 3'b000;
    sda_low_o = 1'b0;
  end
  always @(posedge scl_i) if (act) begin
    if (bitc < 8) sh = {sh[6:0], sda_i};
    else hack = !sda_i;
  end
  always @(negedge scl_i) if (act) begin
    if (fresh) begin
      fresh = 1'b0;
    end else if (bitc < 7) begin
      bitc++;
      if (rd) sda_low_o = !ob[7 - bitc];
    end else if (bitc == 7) begin
      bitc = 4'h8;
      sda_low_o = rd ? 1'b0 : take();
    end else begin
      bitc = 4'h0;
      sda_low_o = 1'b0;
      if (rd && !hack) act = 1'b0;
      else if (rd || rdp) begin
        {rd, rdp} = 2'b10;
        ob = fetch();
        sda_low_o = !ob[7];
      end
      // Longer than half a bit, so the host must wait
      if (slow_i) begin
        scl_low_o = 1'b1;
        #8000;
        scl_low_o = 1'b0;
      end
    end
  end
endmodule : nvc_dev_model

`default_nettype wire

// file: tb/tb_top.sv
// Bench of the serial configuration host: APB tasks order operations
// and a device model answers on the open-drain lines.
// Assumes the design package, its defines and nvc_dev_model.
`include "nvc_defs.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nvc_pkg::*;

  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic slow = 1'b0;
  logic dscl, dsda, err;
  logic [31:0] rd;
  logic [7:0] c0;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  nvc_apb_req_t req = '0;
  nvc_apb_rsp_t rsp;
  nvc_pins_t pins;
  wire logic scl_w = (pins.scl_oe_n | pins.scl_o) & ~dscl;
  wire logic sda_w = (pins.sda_oe_n | pins.sda_o) & ~dsda;

  nvc_host dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .scl_i(scl_w), .sda_i(sda_w), .pins_o(pins));
  // Commit outlasts one poll, so the poll repeats
  nvc_dev_model #(.PROG_NS(600000)) dev (.rst_n_i(nrst_i), .slow_i(slow),
    .scl_i(scl_w),
    .sda_i(sda_w), .scl_low_o(dscl), .sda_low_o(dsda));

  always #50 mclk_i = ~mclk_i;

  // ==================================================================
  // Tasks
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk_i);
    req.penable <= 1'b1;
    do @(posedge mclk_i);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic idle();
    do apb(1'b0, `NVC_A_STAT, 32'h0);
    while (rd[2] !== 1'b0);
  endtask : idle

  task automatic run(input logic [2:0] op, input logic [1:0] strap,
                     input logic [31:0] p, input logic [31:0] d);
    apb(1'b1, `NVC_A_PTR, p);
    apb(1'b1, `NVC_A_DAT0, d);
    apb(1'b1, `NVC_A_CTRL, {26'h0, strap, 1'b1, op});
    idle();
  endtask : run

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      conclude();
    end
  end

  // ==================================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    apb(1'b0, `NVC_A_STAT, 32'h0);
    check(rd, 32'h40);
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, `NVC_A_DAT1, 32'h8877_6655);
    apb(1'b0, `NVC_A_DAT1, 32'h0);
    check(rd, 32'h8877_6655);
    run(3'h0, 2'h1, 32'h0003_0010, 32'h4433_2211);
    check(32'(rd[1:0]), 32'h1);
    for (int i = 0; i < 4; i++)
      check(32'(dev.regs[16 + i]), 32'h11 * (i + 1));
    slow <= 1'b1;
    run(3'h1, 2'h1, 32'h0003_0010, 32'h0);
    apb(1'b0, `NVC_A_DAT0, 32'h0);
    check(rd, 32'h4433_2211);
    slow <= 1'b0;
    run(3'h0, 2'h2, 32'h0000_0010, 32'h0);
    check(32'(rd[1:0]), 32'h3);
    check(32'(dev.regs[16]), 32'h11);
    run(3'h2, 2'h1, 32'h0002_2035, 32'h00cc_bbaa);
    for (int i = 0; i < 3; i++)
      check(32'(dev.sram[32 + i]), 32'haa + 32'h11 * i);
    check(32'(dev.win), 32'h0);
    run(3'h3, 2'h1, 32'h0002_2035, 32'h0);
    apb(1'b0, `NVC_A_DAT0, 32'h0);
    check(rd & 32'hff_ffff, 32'hcc_bbaa);
    run(3'h4, 2'h1, 32'h0003_1035, 32'h0);
    check(32'(dev.regs[49]), 32'h40);
    for (int i = 0; i < 4; i++)
      check(32'(dev.sram[16 + i]), 32'h11 * (i + 1));
    c0 = dev.regs[48];
    apb(1'b1, `NVC_A_CTRL, 32'h1d);
    apb(1'b1, `NVC_A_PTR, 32'h99);
    idle();
    // Done and key-written flags remain set after relock
    check(32'(rd[3:0]), 32'h9);
    check(32'(dev.regs[56]), 32'h0);
    check(32'(dev.regs[49]), 32'h1);
    check(32'(dev.regs[48]), 32'(c0) + 1);
    for (int i = 0; i < 4; i++)
      check(32'(dev.eep[16 + i]), 32'h11 * (i + 1));
    apb(1'b0, `NVC_A_PTR, 32'h0);
    check(rd, 32'h0003_1035);
    run(3'h3, 2'h1, 32'h0003_1034, 32'h0);
    apb(1'b0, `NVC_A_DAT0, 32'h0);
    check(rd, 32'h4433_2211);
    run(3'h1, 2'h1, 32'h0000_0030, 32'h0);
    apb(1'b0, `NVC_A_DAT0, 32'h0);
    check(32'(rd[7:0]), 32'(c0) + 1);
    conclude();
  end
endmodule : tb_top

`default_nettype wire
